//--- ctm_defines.vh
`ifndef CTM_DEFINES_VH
`define CTM_DEFINES_VH
// register word byte addresses on the avalon slave
`define CTM_OFS_CTRL0   4'h0
`define CTM_OFS_CTRL1   4'h4
`define CTM_OFS_CNT     4'h8
`define CTM_OFS_CMPA    4'hc
// word index (address bits 3:2)
`define CTM_IDX_CTRL0   2'h0
`define CTM_IDX_CTRL1   2'h1
`define CTM_IDX_CNT     2'h2
`define CTM_IDX_CMPA    2'h3
// control zero: counter_on and clock divider select
`define CTM_C0_ON       3
`define CTM_C0_DIV_LSB  4
`define CTM_C0_DIV_MSB  6
// control one field positions
`define CTM_C1_MODE_MSB 7
`define CTM_C1_MODE_LSB 6
`define CTM_C1_PIN_MSB  5
`define CTM_C1_PIN_LSB  4
`define CTM_C1_INIT     3
`define CTM_C1_INV      2
`define CTM_C1_SWAP     1
`define CTM_C1_CLRSEL   0
// control one bits 8..15 hold compare_p_value, bits 16/17 the match flags
`define CTM_C1_P_LSB    8
`define CTM_C1_P_MSB    15
`define CTM_C1_FA       16
`define CTM_C1_FP       17
// mode codes
`define CTM_MODE_CMP    2'h0
`define CTM_MODE_PWM    2'h2
`define CTM_MODE_TMR    2'h3
// pin action codes
`define CTM_PIN_NONE    2'h0
`define CTM_PIN_LOW     2'h1
`define CTM_PIN_HIGH    2'h2
`define CTM_PIN_TOG     2'h3
// reset values and counter maximum
`define CTM_RST_CTRL    8'h00
`define CTM_RST_CMPA    16'h0000
`define CTM_RST_CMPP    8'h00
`define CTM_CNT_MAX     16'hffff
`endif

//--- ctm_clk_div.v
`timescale 1ns/1ps
`default_nettype none
// timer clock enable: divide by 2**sel (sel 0 = every cycle)
module ctm_clk_div (
  input  wire       clock_i,  // system clock
  input  wire       rst_i,    // synchronous reset
  input  wire [2:0] sel_i,    // divider select
  output reg        tick_o    // one-cycle timer clock enable
);
  reg [6:0] div_r;  // free running prescaler
  // prescaler counts every system clock
  always @(posedge clock_i) begin
    if (rst_i) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_r + 7'h01;
    end
  end
  // pulse when all low bits selected are ones
  always @(posedge clock_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (sel_i == 3'h0) ? 1'b1 :
        ((div_r | ~((7'h01 << sel_i) - 7'h01)) == 7'h7f);
    end
  end
endmodule // ctm_clk_div
`default_nettype wire

//--- ctm_timer.v
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defines.vh"
module ctm_timer (
  input  wire        clock_i,        // system clock, 10 mhz
  input  wire        rst_i,          // synchronous reset, active high
  input  wire [3:0]  avs_address_i,  // byte address
  input  wire        avs_read_i,     // read strobe
  input  wire        avs_write_i,    // write strobe
  input  wire [31:0] avs_writedata_i,// write data
  input  wire [3:0]  avs_byteenable_i,// byte lanes
  output reg  [31:0] avs_readdata_o, // read data
  output reg         avs_waitrequest_o,// stall
  output reg         timer_pin_o,    // timer output pin level
  output reg         timer_pin_oe_o, // high while the pin is driven
  output reg         match_a_flag_o, // comparator a flag
  output reg         match_p_flag_o  // comparator p flag
);
  // configuration registers, all written from the bus; the counter itself
  // is read only and changes only by counting, clearing or a restart
  reg        counter_on_r;         // counter enable
  reg [2:0]  clk_sel_r;            // timer clock divider select
  reg [7:0]  ctrl1_r;              // timer_control_one
  reg [15:0] compare_a_value_r;    // 16-bit comparator a value
  reg [7:0]  compare_p_value_r;    // 8-bit comparator p value
  reg [15:0] count_r;              // 16-bit counter
  reg        on_dly_r;             // counter_on delayed for edge
  reg        cmp_lvl_r;            // compare mode pin level
  reg        bus_done_r;           // access answered last cycle
  wire       tick;                 // timer clock enable
  wire [1:0] mode = ctrl1_r[`CTM_C1_MODE_MSB:`CTM_C1_MODE_LSB];
  wire [1:0] pin_act = ctrl1_r[`CTM_C1_PIN_MSB:`CTM_C1_PIN_LSB];
  wire       init_lvl = ctrl1_r[`CTM_C1_INIT];
  wire       inv = ctrl1_r[`CTM_C1_INV];
  wire       swap = ctrl1_r[`CTM_C1_SWAP];
  wire       clrsel = ctrl1_r[`CTM_C1_CLRSEL];
  wire       on_rise = counter_on_r & ~on_dly_r;
  wire       is_pwm = (mode == `CTM_MODE_PWM);
  // bus_done_r masks the cycle after an answer, so a request that is still
  // held while waitrequest is low is not taken a second time
  wire       req = (avs_read_i | avs_write_i) & ~bus_done_r;
  wire       wr = avs_write_i & ~bus_done_r;
  wire [1:0] idx = avs_address_i[3:2];

  // merge one byte lane of write data into a stored byte
  function [7:0] lane;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      lane = en ? nw : old;
    end
  endfunction

  // true on the last count before a limit, so that a clear there makes
  // the period equal to the limit; a zero limit wraps to ffff
  function last_count;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      last_count = (cnt == lim - 16'h0001);
    end
  endfunction

  // timer clock: one-cycle enable from the prescaler, every clock at sel 0
  ctm_clk_div u_div (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .sel_i   (clk_sel_r),
    .tick_o  (tick)
  );

  // match conditions on the value the counter holds now
  wire p_zero = (compare_p_value_r == 8'h00);
  wire a_zero = (compare_a_value_r == 16'h0000);
  wire at_max = (count_r == `CTM_CNT_MAX);
  // p comparator sees only the upper byte, so matches step by 256; the
  // hit is taken on the last count below p*256, which makes the period
  // exactly p*256 ticks, and p at zero wraps the limit to ffff
  wire p_hit = last_count(count_r, {compare_p_value_r, 8'h00});
  wire a_hit = ~a_zero & (count_r == compare_a_value_r);
  // pwm with swap: a sets the period, so its hit is also one count early
  wire a_end = last_count(count_r, compare_a_value_r);
  // duty length in ticks, seventeen bits so that 65536 fits
  wire [16:0] duty = swap ? (p_zero ? 17'h10000 :
    {1'b0, compare_p_value_r, 8'h00}) : {1'b0, compare_a_value_r};
  // active phase while the count is below the duty length; a duty at or
  // above the period is never left, which gives 100 percent
  wire pwm_on = ({1'b0, count_r} < duty);
  reg  clr_now;  // counter clears at this tick
  reg  flag_a;   // a flag event this tick
  reg  flag_p;   // p flag event this tick

  // clear source and flag selection per mode
  // the counter clears on the tick after the matching count, so a clear on
  // an end count gives a period equal to the limit
  always @* begin
    clr_now = 1'b0;
    flag_a = 1'b0;
    flag_p = 1'b0;
    if (is_pwm) begin
      // clear select ignored; swap picks period register
      flag_a = swap ? a_end : a_hit;
      flag_p = p_hit;
      clr_now = swap ? a_end : p_hit;
    end else if (clrsel) begin
      // only a clears, p silent; a zero runs to ffff
      flag_a = a_hit;
      clr_now = a_hit | at_max;
    end else begin
      // p clears or overflow, both flags
      flag_a = a_hit;
      flag_p = p_hit;
      clr_now = p_hit;
    end
  end

  // counter: zero on enable rise, hold when off, count on tick
  // a restart wins over a tick in the same cycle, so the first count after
  // counter_on rises is always zero
  always @(posedge clock_i) begin
    if (rst_i) begin
      count_r <= 16'h0000;
    end else if (on_rise) begin
      count_r <= 16'h0000;
    end else if (counter_on_r & tick) begin
      count_r <= clr_now ? 16'h0000 : count_r + 16'h0001;
    end
  end

  // sticky flags, set wins over software clear
  // a hit in the same cycle as a write-one-to-clear keeps the flag set, so
  // software never loses an event that lands during its clear
  always @(posedge clock_i) begin
    if (rst_i) begin
      match_a_flag_o <= 1'b0;
      match_p_flag_o <= 1'b0;
    end else begin
      if (counter_on_r & tick & ~on_rise & flag_a) begin
        match_a_flag_o <= 1'b1;
      end else if (wr & idx == `CTM_IDX_CTRL1 & avs_byteenable_i[2]
                   & avs_writedata_i[`CTM_C1_FA]) begin
        match_a_flag_o <= 1'b0; // write one to clear
      end
      if (counter_on_r & tick & ~on_rise & flag_p) begin
        match_p_flag_o <= 1'b1;
      end else if (wr & idx == `CTM_IDX_CTRL1 & avs_byteenable_i[2]
                   & avs_writedata_i[`CTM_C1_FP]) begin
        match_p_flag_o <= 1'b0;
      end
    end
  end

  // compare mode pin level
  // loaded on restart, then moved only by an a match; codes that ask for
  // the level the pin already has leave it as it is
  always @(posedge clock_i) begin
    if (rst_i) begin
      cmp_lvl_r <= 1'b0;
    end else if (on_rise) begin
      cmp_lvl_r <= init_lvl;
    end else if (counter_on_r & tick) begin
      // only an a match moves the pin
      if (flag_a & mode == `CTM_MODE_CMP) begin
        case (pin_act)
          `CTM_PIN_LOW:  cmp_lvl_r <= 1'b0;
          `CTM_PIN_HIGH: cmp_lvl_r <= 1'b1;
          `CTM_PIN_TOG:  cmp_lvl_r <= ~cmp_lvl_r;
          default:       cmp_lvl_r <= cmp_lvl_r;
        endcase
      end
    end
  end

  reg pin_nxt;  // next pin level
  // pwm: init bit gives the active level, invert flips the final pin;
  // the forced codes still let the counter and flags run
  // output pin per mode, polarity and invert
  always @* begin
    pin_nxt = 1'b0;
    case (mode)
      `CTM_MODE_CMP: pin_nxt = cmp_lvl_r ^ inv;
      `CTM_MODE_PWM: begin
        // forced codes leave counting alone
        case (pin_act)
          `CTM_PIN_NONE: pin_nxt = ~init_lvl;
          `CTM_PIN_LOW:  pin_nxt = init_lvl;
          `CTM_PIN_HIGH: pin_nxt = pwm_on ? init_lvl : ~init_lvl;
          default:       pin_nxt = ~init_lvl;
        endcase
        pin_nxt = pin_nxt ^ inv;
      end
      default: pin_nxt = 1'b0; // timer mode pin unused
    endcase
  end

  // pin register and enable
  // timer mode releases the pin: oe low lets it serve other functions
  always @(posedge clock_i) begin
    if (rst_i) begin
      timer_pin_o <= 1'b0;
      timer_pin_oe_o <= 1'b0;
    end else begin
      timer_pin_o <= pin_nxt;
      timer_pin_oe_o <= (mode == `CTM_MODE_CMP) | is_pwm;
    end
  end

  // register writes
  // byte lanes: lane 0 holds the control bits, lane 1 the p value, lane 2
  // the flag clears handled in the flag process; unused lanes are ignored
  // mode and pin action should only change while the counter is stopped;
  // the block does not lock them, so a change mid-period takes effect now
  always @(posedge clock_i) begin
    if (rst_i) begin
      counter_on_r <= 1'b0;
      clk_sel_r <= 3'h0;
      ctrl1_r <= `CTM_RST_CTRL;
      compare_a_value_r <= `CTM_RST_CMPA;
      compare_p_value_r <= `CTM_RST_CMPP;
    end else if (wr) begin
      case (idx)
        `CTM_IDX_CTRL0: begin
          if (avs_byteenable_i[0]) begin
            counter_on_r <= avs_writedata_i[`CTM_C0_ON];
            clk_sel_r <= avs_writedata_i[`CTM_C0_DIV_MSB:`CTM_C0_DIV_LSB];
          end
        end
        `CTM_IDX_CTRL1: begin
          ctrl1_r <= lane(ctrl1_r, avs_writedata_i[7:0],
                          avs_byteenable_i[0]);
          compare_p_value_r <= lane(compare_p_value_r,
                                    avs_writedata_i[15:8],
                                    avs_byteenable_i[1]);
        end
        `CTM_IDX_CMPA: begin
          compare_a_value_r[7:0] <= lane(compare_a_value_r[7:0],
                                         avs_writedata_i[7:0],
                                         avs_byteenable_i[0]);
          compare_a_value_r[15:8] <= lane(compare_a_value_r[15:8],
                                          avs_writedata_i[15:8],
                                          avs_byteenable_i[1]);
        end
        default: begin
          counter_on_r <= counter_on_r; // counter read only
        end
      endcase
    end
  end

  // edge detect history
  // counter_on is a register on this clock, so no synchroniser is needed
  always @(posedge clock_i) begin
    if (rst_i) begin
      on_dly_r <= 1'b0;
    end else begin
      on_dly_r <= counter_on_r;
    end
  end

  // avalon answer: waitrequest low one cycle after the request appears
  // reads return the value at the edge the request is taken; the master
  // picks it up one edge later while waitrequest is low
  always @(posedge clock_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      bus_done_r <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~req;
      bus_done_r <= req;
      if (avs_read_i & ~bus_done_r) begin
        case (idx)
          `CTM_IDX_CTRL0: avs_readdata_o <=
            {25'h0000000, clk_sel_r, counter_on_r, 3'h0};
          `CTM_IDX_CTRL1: avs_readdata_o <=
            {14'h0000, match_p_flag_o, match_a_flag_o,
             compare_p_value_r, ctrl1_r};
          `CTM_IDX_CNT:  avs_readdata_o <= {16'h0000, count_r};
          default:       avs_readdata_o <= {16'h0000, compare_a_value_r};
        endcase
      end
    end
  end
endmodule // ctm_timer
`default_nettype wire

//--- ctm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches bus handshake, flags and pin against the timer setup
module ctm_monitor (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        timer_pin_o,
  input wire logic        timer_pin_oe_o,
  input wire logic        match_a_flag_o,
  input wire logic        match_p_flag_o
);
  logic [7:0] c1_r;  // shadow of control one low byte
  logic       on_r;  // shadow of counter_on
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // shadows follow accepted writes, one cycle behind the block
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      c1_r <= 8'h00;
      on_r <= 1'b0;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i[3:2] == 2'h1) c1_r <= avs_writedata_i[7:0];
      if (avs_address_i[3:2] == 2'h0) on_r <= avs_writedata_i[3];
    end
  end
  // request waiting for its answer
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // pwm with the pin forced while running
  sequence s_forced;
    c1_r[7:6] == 2'h2 && !c1_r[5] && on_r;
  endsequence
  wait_pulse_a: assert property ($fell(avs_waitrequest_o) |=>
    avs_waitrequest_o) else $error("waitrequest low too long");
  answer_cause_a: assert property ($fell(avs_waitrequest_o) |->
    $past(avs_read_i) || $past(avs_write_i)) else $error("stray answer");
  answer_bound_a: assert property (s_req |-> ##[1:2] !avs_waitrequest_o)
    else $error("request not answered");
  rdata_hold_a: assert property (!avs_read_i && !$past(avs_read_i) |->
    $stable(avs_readdata_o)) else $error("read data moved");
  flag_a_keep_a: assert property (match_a_flag_o |=> match_a_flag_o ||
    avs_write_i) else $error("a flag lost");
  flag_p_keep_a: assert property (match_p_flag_o |=> match_p_flag_o ||
    avs_write_i) else $error("p flag lost");
  pclr_only_a: assert property ($rose(match_p_flag_o) |->
    !(c1_r[0] && c1_r[7:6] != 2'h2)) else $error("p flag with a clear");
  tmr_nopin_a: assert property ((c1_r[7:6] == 2'h3)[*3] |->
    !timer_pin_oe_o) else $error("pin driven in timer mode");
  pwm_force_a: assert property (s_forced[*5] |->
    timer_pin_o == !(c1_r[4] ^ c1_r[3] ^ c1_r[2])) else $error("bad force");
endmodule  // ctm_monitor
bind ctm_timer ctm_monitor mon (.clock_i(clock_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .timer_pin_o(timer_pin_o), .timer_pin_oe_o(timer_pin_oe_o),
  .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
// drives the timer over its register bus and checks pin and flags
module testbench;
  logic        clock_i, rst_i, avs_read_i, avs_write_i;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, timer_pin_o, timer_pin_oe_o;
  wire         match_a_flag_o, match_p_flag_o;
  int          n_errors, checked;
  logic [31:0] q, h, c;  // read data, pin high count, saved count
  // pwm cases: control one, compare a, window, expected high cycles
  logic [31:0] pc[7] = '{32'h301a9, 32'h301ad, 32'h301a1, 32'h301a9,
                         32'h301ab, 32'h30189, 32'h30199};
  logic [15:0] pa[7] = '{16'h40, 16'h40, 16'h40, 16'h100, 16'h400,
                         16'h40, 16'h40};
  int          pw[7] = '{512, 512, 512, 512, 2048, 512, 512};
  int          pe[7] = '{128, 384, 384, 512, 512, 0, 512};
  ctm_timer dut (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .timer_pin_o(timer_pin_o),
    .timer_pin_oe_o(timer_pin_oe_o), .match_a_flag_o(match_a_flag_o),
    .match_p_flag_o(match_p_flag_o));
  // clock, 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= ~w;
    avs_write_i <= w;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // stop, configure, restart; the write to control one clears flags
  task automatic setup(input logic [31:0] c1, input logic [15:0] a);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'hc, {16'h0, a});
    bus(1'b1, 4'h4, c1);
    bus(1'b1, 4'h0, 32'h8);
  endtask
  // pin high cycles over a window
  task automatic high(input int cyc);
    h = 32'h0;
    repeat (cyc) begin
      @(posedge clock_i);
      h = h + {31'h0, timer_pin_o};
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #5000000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {rst_i, avs_read_i, avs_write_i} <= 3'b100;
    avs_address_i <= 4'h0;
    avs_writedata_i <= 32'h0;
    avs_byteenable_i <= 4'hf;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk({avs_waitrequest_o, timer_pin_oe_o, match_a_flag_o}, 32'h4);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    // compare mode, clear on a, p below a, toggle pin
    setup(32'h30131, 16'h0300);
    repeat (3) @(posedge clock_i);
    chk(timer_pin_o, 32'h0);
    repeat (800) @(posedge clock_i);
    chk({match_p_flag_o, match_a_flag_o, timer_pin_o}, 32'h3);
    bus(1'b0, 4'h8, 32'h0);
    chk(q < 32'h300, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    c = q;
    repeat (20) @(posedge clock_i);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, c);
    // compare mode, clear on p, pin high on a
    setup(32'h30120, 16'h0005);
    repeat (300) @(posedge clock_i);
    chk({match_p_flag_o, match_a_flag_o, timer_pin_o}, 32'h7);
    bus(1'b0, 4'h8, 32'h0);
    chk(q < 32'h100, 32'h1);
    // a at zero runs on with no a flag
    setup(32'h30131, 16'h0000);
    repeat (600) @(posedge clock_i);
    chk(match_a_flag_o, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(q > 32'h200, 32'h1);
    // timer mode flags like compare, pin not driven
    setup(32'h301f1, 16'h0010);
    repeat (40) @(posedge clock_i);
    chk({timer_pin_oe_o, match_a_flag_o}, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h8);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h10);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h101f1);
    // pwm cases
    for (int i = 0; i < 7; i++) begin
      setup(pc[i], pa[i]);
      repeat (300) @(posedge clock_i);
      high(pw[i]);
      chk(h, pe[i]);
      chk({match_p_flag_o, timer_pin_oe_o}, 32'h3);
      chk(match_a_flag_o, pa[i] != 16'h100);
    end
    give_verdict;
  end
endmodule  // testbench
`default_nettype wire
